//--- clock_bank_pkg.sv
// Shared constants, types and select decoders for the clock bank control
package clock_bank_pkg;

  // Three-level strap code; an open pin reads as the middle level
  typedef logic [1:0] tri_t;
  localparam tri_t TRI_LOW = 2'h0;
  localparam tri_t TRI_MID = 2'h1;
  localparam tri_t TRI_HIGH = 2'h2;

  localparam int BANKS = 4;
  localparam int OUTS_PER_BANK = 4;
  localparam int LOOP_OUTS = 2;
  localparam int DIVIDERS = 5;
  localparam int LOOP_IDX = 4;
  localparam int INV_BANK = 2;
  localparam int PERIOD_W = 10;
  localparam int OFFSET_W = 5;

  // Oscillator cycles per nominal output period, one cycle per time unit
  localparam logic [6:0] RANGE_N_LOW = 7'h40;
  localparam logic [6:0] RANGE_N_MID = 7'h20;
  localparam logic [6:0] RANGE_N_HIGH = 7'h10;

  // Divide ratios for select indices LL..HH
  localparam logic [8:0][3:0] DIV_TABLE = {
    4'hC, 4'hA, 4'h8, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1};

  localparam logic [3:0] IDX_CENTER = 4'h4;
  localparam logic [3:0] IDX_COPY1 = 4'h3;
  localparam logic [3:0] IDX_COPY2 = 4'h5;
  localparam logic signed [OFFSET_W-1:0] LOOP_STEP = 5'sh04;
  localparam logic signed [OFFSET_W-1:0] FAR_BASE = 5'sh08;
  localparam logic signed [OFFSET_W-1:0] FAR_SPAN = 5'sh02;

  // Lock detection timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int LOCK_WINDOW_NS = 40;
  localparam int LOCK_WINDOW_CYC_I = (LOCK_WINDOW_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                     (LOCK_WINDOW_NS / CLK_PERIOD_NS);
  localparam logic [PERIOD_W-1:0] LOCK_WINDOW_CYC = PERIOD_W'(LOCK_WINDOW_CYC_I);
  localparam logic [4:0] LOCK_COUNT = 5'h10;
  localparam logic [11:0] REF_TIMEOUT_CYC = 12'h800;

  // Values after reset
  localparam logic RST_LOW = 1'h0;
  localparam logic RST_OE_N = 1'h1;

  function automatic logic [1:0] tri_level(input tri_t v);
    return (v == TRI_LOW) ? 2'h0 : ((v == TRI_HIGH) ? 2'h2 : 2'h1);
  endfunction

  function automatic logic [3:0] sel_index(input tri_t hi, input tri_t lo);
    logic [3:0] h;
    h = {2'h0, tri_level(hi)};
    return (h << 1) + h + {2'h0, tri_level(lo)};
  endfunction

  function automatic logic [6:0] range_factor(input tri_t v);
    logic [1:0] l;
    l = tri_level(v);
    return (l == 2'h0) ? RANGE_N_LOW : ((l == 2'h2) ? RANGE_N_HIGH : RANGE_N_MID);
  endfunction

endpackage

//--- phase_divider.sv
// Divided, phase-shifted clock generator counting oscillator cycles
`timescale 1ns/10ps
`default_nettype none
module phase_divider
  import clock_bank_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic restart_in,
  input wire logic [PERIOD_W-1:0] period_in,
  input wire logic signed [OFFSET_W-1:0] offset_in,
  output logic clk_out
);
  logic [PERIOD_W-1:0] count;
  logic [PERIOD_W:0] shifted;
  logic [PERIOD_W:0] wrapped;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
    end else if (restart_in || count >= period_in - PERIOD_W'(1)) begin
      count <= '0;
    end else begin
      count <= count + PERIOD_W'(1);
    end
  end

  // A later phase samples an earlier count; offsets never exceed one period
  always_comb begin
    shifted = {1'h0, count} - (PERIOD_W+1)'(offset_in);
    if (shifted[PERIOD_W]) begin
      wrapped = shifted + {1'h0, period_in};
    end else if (shifted >= {1'h0, period_in}) begin
      wrapped = shifted - {1'h0, period_in};
    end else begin
      wrapped = shifted;
    end
  end

  // Every period is even, so the high half is exact
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_out <= RST_LOW;
    end else begin
      clk_out <= wrapped < {2'h0, period_in[PERIOD_W-1:1]};
    end
  end
endmodule
`default_nettype wire

//--- loop_phase_detector.sv
// Phase-frequency detector and lock qualifier for reference and feedback
`timescale 1ns/10ps
`default_nettype none
module loop_phase_detector
  import clock_bank_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ref_in,
  input wire logic fb_in,
  input wire logic restart_in,
  output logic osc_up_out,
  output logic osc_down_out,
  output logic locked_out
);
  logic ref_prev;
  logic fb_prev;
  logic ref_rise;
  logic fb_rise;
  logic next_up;
  logic next_down;
  logic both;
  logic [PERIOD_W-1:0] skew;
  logic [4:0] match;
  logic [11:0] idle;

  assign ref_rise = ref_in && !ref_prev;
  assign fb_rise = fb_in && !fb_prev;
  assign next_up = osc_up_out || ref_rise;
  assign next_down = osc_down_out || fb_rise;
  assign both = next_up && next_down;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_prev <= RST_LOW;
      fb_prev <= RST_LOW;
    end else begin
      ref_prev <= ref_in;
      fb_prev <= fb_in;
    end
  end

  // Late feedback asks for a faster oscillator, early feedback a slower one
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_up_out <= RST_LOW;
      osc_down_out <= RST_LOW;
    end else if (restart_in || both) begin
      osc_up_out <= RST_LOW;
      osc_down_out <= RST_LOW;
    end else begin
      osc_up_out <= next_up;
      osc_down_out <= next_down;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      skew <= '0;
    end else if (restart_in || both || !(next_up || next_down)) begin
      skew <= '0;
    end else if (skew != '1) begin
      skew <= skew + PERIOD_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle <= '0;
    end else if (restart_in || ref_rise) begin
      idle <= '0;
    end else if (idle != REF_TIMEOUT_CYC) begin
      idle <= idle + 12'h001;
    end
  end

  // A lost reference or one wide skew restarts the qualification
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      match <= '0;
    end else if (restart_in || idle == REF_TIMEOUT_CYC) begin
      match <= '0;
    end else if (both) begin
      if (skew > LOCK_WINDOW_CYC) begin
        match <= '0;
      end else if (match != LOCK_COUNT) begin
        match <= match + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      locked_out <= RST_LOW;
    end else begin
      locked_out <= (match == LOCK_COUNT) && !restart_in && idle != REF_TIMEOUT_CYC;
    end
  end
endmodule
`default_nettype wire

//--- multiphase_clock_bank_ctrl.sv
// Control logic of a four-bank multiphase clock buffer with feedback bank
//
// Contract
// [R1] Feedback bank divide ratio comes from its two three-level divide selects.
// [R2] Feedback disable high puts both feedback outputs in the chosen off state.
// [R3] Feedback disable low lets both feedback outputs drive their clock.
// [R4] Unconnected disable pins read low, so banks default to enabled.
// [R5] A bank disable high puts that bank's outputs in the chosen off state.
// [R6] A bank disable low lets all four bank outputs drive their clocks.
// [R7] Each bank's phase offset comes from its own two phase selects.
// [R8] Each bank's divide ratio comes from its own two divide selects.
// [R9] Bank 3 polarity low inverts the second output of each pair only.
// [R10] Bank 3 polarity high inverts all four bank 3 outputs.
// [R11] Bank 3 polarity middle leaves all four bank 3 outputs non-inverted.
// [R12] Lock flag is high when locked and low while acquiring.
// [R13] Off-state select high sends disabled outputs to high impedance.
// [R14] Off-state select low sends disabled outputs to hold-off.
// [R15] Off-state select middle enters the factory test mode.
// [R16] Feedback bank has many divide ratios but only three phase offsets.
// [R17] The board routes one feedback output back to the selected feedback input.
// [R18] Selected reference and feedback are compared to steer the oscillator.
// [R19] Reference may switch live; periods never shorten while relocking.
// [R20] Three-level selects read high, low, or middle when open.
// [R21] Divide select pairs map LL..HH to 1,2,3,4,5,6,8,10,12.
// [R22] Offsets: banks 1-2 -4..+4, banks 3-4 far or copy, feedback -4,0,+4.
// [R23] Time unit is one over nominal frequency times range factor N.
// [R24] Hold-off finishes the current cycle then holds low, never a runt.
// [R25] All outputs derive from one oscillator clock with fixed edge relation.
`timescale 1ns/10ps
`default_nettype none
module multiphase_clock_bank_ctrl
  import clock_bank_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ref_a_in,
  input wire logic ref_b_in,
  input wire logic ref_sel_in,
  input wire logic fb_a_in,
  input wire logic fb_b_in,
  input wire logic fb_sel_in,
  input wire tri_t range_sel_in,
  input wire tri_t off_state_sel_in,
  input wire tri_t [1:0] feedback_divide_sel_in,
  input wire tri_t loop_phase_sel_in,
  input wire logic feedback_bank_off_in,
  input wire tri_t [BANKS-1:0][1:0] bank_divide_sel_in,
  input wire tri_t [BANKS-1:0][1:0] bank_phase_sel_in,
  input wire logic [BANKS-1:0] bank_off_in,
  input wire tri_t bank3_polarity_sel_in,
  output logic [BANKS*OUTS_PER_BANK-1:0] bank_clk_out,
  output logic [BANKS*OUTS_PER_BANK-1:0] bank_clk_oe_n_out,
  output logic [LOOP_OUTS-1:0] loop_out_pair_out,
  output logic [LOOP_OUTS-1:0] loop_out_oe_n_out,
  output logic lock_out,
  output logic osc_up_out,
  output logic osc_down_out,
  output logic test_mode_out
);
  logic [PERIOD_W-1:0] period [DIVIDERS];
  logic [PERIOD_W-1:0] next_period [DIVIDERS];
  logic signed [OFFSET_W-1:0] offset [DIVIDERS];
  logic signed [OFFSET_W-1:0] next_offset [DIVIDERS];
  logic [DIVIDERS-1:0] div_clk;
  logic [DIVIDERS-1:0] gate;
  logic [DIVIDERS-1:0] off_req;
  logic gate_inv;
  logic restart;
  logic next_restart;
  logic ref_sel_prev;
  logic ref_switch;
  logic ref_mux;
  logic fb_mux;
  logic locked;
  logic [6:0] range_n;
  logic [1:0] mode_level;
  logic [1:0] pol_level;
  logic [BANKS*OUTS_PER_BANK-1:0] next_bank_clk;
  logic [BANKS*OUTS_PER_BANK-1:0] next_bank_oe_n;
  logic [LOOP_OUTS-1:0] next_loop_clk;
  logic [LOOP_OUTS-1:0] next_loop_oe_n;

  // Offset of a near bank: select index 0..8 gives -4..+4 units
  function automatic logic signed [OFFSET_W-1:0] near_offset(input logic [3:0] idx);
    return $signed({1'h0, idx}) - $signed({1'h0, IDX_CENTER});
  endfunction

  // Offset of a far bank; the two copy codes are resolved by the caller
  function automatic logic signed [OFFSET_W-1:0] far_offset(input logic [3:0] idx);
    logic signed [OFFSET_W-1:0] step;
    step = $signed({1'h0, idx % 4'h3});
    if (idx == IDX_CENTER) begin
      return '0;
    end else if (idx < IDX_COPY1) begin
      return step - FAR_BASE;
    end else begin
      return FAR_BASE - FAR_SPAN + step;
    end
  endfunction

  function automatic logic [PERIOD_W-1:0] period_of(input tri_t hi, input tri_t lo,
                                                   input logic [6:0] n);
    return PERIOD_W'(n) * PERIOD_W'(DIV_TABLE[sel_index(hi, lo)]);
  endfunction

  assign range_n = range_factor(range_sel_in); // [R23] [R20]
  assign mode_level = tri_level(off_state_sel_in); // [R20]
  assign pol_level = tri_level(bank3_polarity_sel_in); // [R20]

  // Configuration decode for the four output banks and the feedback bank
  always_comb begin
    for (int b = 0; b < BANKS; b++) begin
      next_period[b] = period_of(bank_divide_sel_in[b][1], bank_divide_sel_in[b][0],
                                 range_n); // [R8] [R21]
    end
    next_period[LOOP_IDX] = period_of(feedback_divide_sel_in[1], feedback_divide_sel_in[0],
                                      range_n); // [R1] [R21] [R16]
    for (int b = 0; b < 2; b++) begin
      next_offset[b] = near_offset(sel_index(bank_phase_sel_in[b][1],
                                             bank_phase_sel_in[b][0])); // [R7] [R22]
    end
    for (int b = 2; b < BANKS; b++) begin
      unique case (sel_index(bank_phase_sel_in[b][1], bank_phase_sel_in[b][0]))
        IDX_COPY1: next_offset[b] = next_offset[0]; // [R22]
        IDX_COPY2: next_offset[b] = next_offset[1]; // [R22]
        default: next_offset[b] = far_offset(sel_index(bank_phase_sel_in[b][1],
                                                       bank_phase_sel_in[b][0])); // [R7]
      endcase
    end
    unique case (tri_level(loop_phase_sel_in))
      2'h0: next_offset[LOOP_IDX] = -LOOP_STEP; // [R16] [R22]
      2'h2: next_offset[LOOP_IDX] = LOOP_STEP; // [R16] [R22]
      default: next_offset[LOOP_IDX] = '0; // [R16]
    endcase
  end

  // A ratio change restarts every divider together, keeping edges aligned
  always_comb begin
    next_restart = 1'h0;
    for (int i = 0; i < DIVIDERS; i++) begin
      if (next_period[i] != period[i]) begin
        next_restart = 1'h1; // [R25]
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < DIVIDERS; i++) begin
        period[i] <= '0;
        offset[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DIVIDERS; i++) begin
        period[i] <= next_period[i];
        offset[i] <= next_offset[i];
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      restart <= 1'h1;
    end else begin
      restart <= next_restart;
    end
  end

  // Every divider counts the same oscillator clock
  generate
    for (genvar g = 0; g < DIVIDERS; g++) begin : gen_div
      phase_divider u_div (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .restart_in(restart),
        .period_in(period[g]),
        .offset_in(offset[g]),
        .clk_out(div_clk[g])
      ); // [R25]
    end
  endgenerate

  // Pins carry pull-downs, so an open disable arrives here as low
  assign off_req = {feedback_bank_off_in, bank_off_in}; // [R4]

  // Enable changes only while the divided clock is low, so no runt appears
  generate
    for (genvar g = 0; g < DIVIDERS; g++) begin : gen_gate
      always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          gate[g] <= RST_LOW;
        end else if (!div_clk[g]) begin
          gate[g] <= !off_req[g]; // [R2] [R3] [R5] [R6] [R24]
        end
      end
    end
  endgenerate

  // Inverted bank 3 outputs are low while the clock is high, so gate them there
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      gate_inv <= RST_LOW;
    end else if (div_clk[INV_BANK]) begin
      gate_inv <= !off_req[INV_BANK]; // [R24] [R5] [R6]
    end
  end

  // Output pins: disabled outputs hold low, or float when high impedance is chosen
  always_comb begin
    logic inv;
    logic en;
    inv = 1'h0;
    en = 1'h0;
    for (int b = 0; b < BANKS; b++) begin
      for (int k = 0; k < OUTS_PER_BANK; k++) begin
        inv = 1'h0;
        if (b == INV_BANK) begin
          unique case (pol_level)
            2'h0: inv = k[0]; // [R9]
            2'h2: inv = 1'h1; // [R10]
            default: inv = 1'h0; // [R11]
          endcase
        end
        en = inv ? gate_inv : gate[b];
        next_bank_clk[b*OUTS_PER_BANK+k] = en && (div_clk[b] ^ inv); // [R14] [R24] [R6]
        next_bank_oe_n[b*OUTS_PER_BANK+k] = !en && mode_level == 2'h2; // [R13] [R5]
      end
    end
    for (int k = 0; k < LOOP_OUTS; k++) begin
      next_loop_clk[k] = gate[LOOP_IDX] && div_clk[LOOP_IDX]; // [R3] [R14]
      next_loop_oe_n[k] = !gate[LOOP_IDX] && mode_level == 2'h2; // [R2] [R13]
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_clk_out <= '0;
      bank_clk_oe_n_out <= '1;
      loop_out_pair_out <= '0;
      loop_out_oe_n_out <= '1;
    end else begin
      bank_clk_out <= next_bank_clk;
      bank_clk_oe_n_out <= next_bank_oe_n;
      loop_out_pair_out <= next_loop_clk;
      loop_out_oe_n_out <= next_loop_oe_n;
    end
  end

  // Middle level on the off-state select is reserved for factory test
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      test_mode_out <= RST_LOW;
    end else begin
      test_mode_out <= mode_level == 2'h1; // [R15]
    end
  end

  // Input selection; the loop only closes once the board wires a feedback output back
  assign ref_mux = ref_sel_in ? ref_b_in : ref_a_in; // [R18]
  assign fb_mux = fb_sel_in ? fb_b_in : fb_a_in; // [R17] [R18]

  // Outputs keep counting the oscillator through a switch, so no period shortens
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_sel_prev <= RST_LOW;
    end else begin
      ref_sel_prev <= ref_sel_in;
    end
  end

  assign ref_switch = ref_sel_in != ref_sel_prev; // [R19]

  loop_phase_detector u_detect (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .ref_in(ref_mux),
    .fb_in(fb_mux),
    .restart_in(ref_switch),
    .osc_up_out(osc_up_out),
    .osc_down_out(osc_down_out),
    .locked_out(locked)
  ); // [R18] [R19]

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_out <= RST_LOW;
    end else begin
      lock_out <= locked && !ref_switch; // [R12]
    end
  end
endmodule
`default_nettype wire

//--- multiphase_clock_bank_ctrl_monitor.sv
// Port-level checker for the clock bank control, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module clock_bank_ctrl_monitor
  import clock_bank_pkg::*;
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ref_a_in,
  input wire logic ref_b_in,
  input wire logic ref_sel_in,
  input wire logic fb_a_in,
  input wire logic fb_sel_in,
  input wire tri_t off_state_sel_in,
  input wire logic feedback_bank_off_in,
  input wire logic [BANKS-1:0] bank_off_in,
  input wire tri_t bank3_polarity_sel_in,
  input wire logic [BANKS*OUTS_PER_BANK-1:0] bank_clk_out,
  input wire logic [BANKS*OUTS_PER_BANK-1:0] bank_clk_oe_n_out,
  input wire logic [LOOP_OUTS-1:0] loop_out_pair_out,
  input wire logic [LOOP_OUTS-1:0] loop_out_oe_n_out,
  input wire logic lock_out,
  input wire logic osc_down_out,
  input wire logic osc_up_out,
  input wire logic test_mode_out
);
  logic mid;
  logic sref;
  logic sref_q;
  logic [11:0] idle;
  logic [9:0] off_cnt;
  logic [9:0] fb_cnt;
  assign mid = (off_state_sel_in == TRI_MID) || (off_state_sel_in == 2'h3);
  assign sref = ref_sel_in ? ref_b_in : ref_a_in;
  // Counters saturate so a long hold never wraps back into range
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sref_q <= 1'h0;
      idle <= 12'h000;
      off_cnt <= 10'h000;
      fb_cnt <= 10'h000;
    end else begin
      sref_q <= sref;
      idle <= (sref && !sref_q) ? 12'h000 : idle + {11'h000, idle != 12'hfff};
      off_cnt <= (bank_off_in[0] && off_state_sel_in == TRI_HIGH) ?
                 off_cnt + {9'h000, off_cnt != 10'h3ff} : 10'h000;
      fb_cnt <= feedback_bank_off_in ? fb_cnt + {9'h000, fb_cnt != 10'h3ff} : 10'h000;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  sequence held_mid;
    mid [*2];
  endsequence
  sequence fb_rise_alone;
    $rose(fb_a_in) && !fb_sel_in && !ref_sel_in && $stable(ref_sel_in) &&
    !$rose(ref_a_in) && !osc_up_out && !osc_down_out;
  endsequence
  a_down_on_fb: assert property (fb_rise_alone |-> ##[1:3] osc_down_out)
    else $error("feedback lead gave no down pulse");
  a_test_mode_on: assert property (held_mid |-> test_mode_out)
    else $error("test mode flag missing");
  a_test_mode_off: assert property ((!mid) [*2] |-> !test_mode_out)
    else $error("test mode flag stuck");
  a_holdoff_driven: assert property ((off_state_sel_in == TRI_LOW) [*3] |->
    bank_clk_oe_n_out == '0 && loop_out_oe_n_out == '0) else $error("hold-off not driven");
  a_hiz_bank_off: assert property (off_cnt == 10'h320 |->
    bank_clk_oe_n_out[3:0] == 4'hf && bank_clk_out[3:0] == 4'h0) else $error("bank not off");
  a_loop_off_low: assert property (fb_cnt == 10'h320 |-> loop_out_pair_out == 2'h0)
    else $error("feedback bank not off");
  a_pair_complement: assert property ((bank3_polarity_sel_in == TRI_LOW && !bank_off_in[2])
    [*3] |-> bank_clk_out[9] != bank_clk_out[8] && bank_clk_out[11] != bank_clk_out[10])
    else $error("bank 3 pairs not complementary");
  a_bank3_uniform: assert property ((bank3_polarity_sel_in != TRI_LOW && !bank_off_in[2])
    [*3] |-> bank_clk_out[11:8] == 4'h0 || bank_clk_out[11:8] == 4'hf)
    else $error("bank 3 outputs disagree");
  a_refsel_clears: assert property ($changed(ref_sel_in) |-> ##[1:2] !lock_out)
    else $error("lock kept over reference swap");
  a_ref_timeout: assert property (idle > 12'h80c |-> !lock_out)
    else $error("lock kept without reference");
endmodule
bind multiphase_clock_bank_ctrl clock_bank_ctrl_monitor u_mon (
  .clk_in, .nrst_in, .ref_a_in, .ref_b_in, .ref_sel_in, .fb_a_in, .fb_sel_in,
  .off_state_sel_in, .feedback_bank_off_in, .bank_off_in, .bank3_polarity_sel_in,
  .bank_clk_out, .bank_clk_oe_n_out, .loop_out_pair_out, .loop_out_oe_n_out,
  .lock_out, .osc_down_out, .osc_up_out, .test_mode_out);
`default_nettype wire

//--- board_clock_model.sv
// Board-side model: reference source and feedback trace
`timescale 1ns/10ps
`default_nettype none
module board_clock_model (
  input wire logic clk_in,
  input wire logic run_in,
  input wire logic align_in,
  input wire logic fb_src_in,
  output logic ref_a_out,
  output logic ref_b_out,
  output logic fb_a_out,
  output logic fb_b_out
);
  logic on = 1'b0;
  logic fb_q = 1'b0;
  logic [3:0] ph = 4'h0;
  assign fb_a_out = fb_src_in;
  assign fb_b_out = fb_src_in;
  // Both sources share one frequency, so a live swap keeps the phase
  assign ref_a_out = on && !ph[3];
  assign ref_b_out = ref_a_out;
  always @(posedge clk_in) begin
    fb_q <= fb_src_in;
    ph <= ph + 4'h1;
    if (!run_in) begin
      on <= 1'b0;
    end else if (align_in && fb_src_in && !fb_q && !on) begin
      on <= 1'b1;
      ph <= 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- tb_multiphase_clock_bank_ctrl.sv
// Self-checking bench for the clock bank control
`timescale 1ns/10ps
`default_nettype none
module tb_multiphase_clock_bank_ctrl
  import clock_bank_pkg::*;
;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ref_sel = 1'b0, align = 1'b0, run = 1'b0, fb_off = 1'b0, fb_sel = 1'b0;
  tri_t range = TRI_HIGH, off_st = TRI_LOW, lph = TRI_MID, pol = TRI_MID;
  tri_t [1:0] fdsel = 4'h0;
  tri_t [BANKS-1:0][1:0] dsel = 16'h0000, psel = 16'h5555;
  logic [BANKS-1:0] boff = 4'h0; // Pulled-down disables read as enabled
  logic ref_a, ref_b, fb_a, fb_b, lock, up, dn, tmode;
  logic [15:0] bclk, boe;
  logic [1:0] lclk, loe;
  logic [17:0] all_clk;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  int dv[9] = '{1, 2, 3, 4, 5, 6, 8, 10, 12};
  int o1[9] = '{-4, -3, -2, -1, 0, 1, 2, 3, 4};
  int o3[9] = '{-8, -7, -6, 3, 0, 0, 6, 7, 8};
  assign all_clk = {lclk, bclk};
  always #10 clk_in = ~clk_in;
  multiphase_clock_bank_ctrl dut (.clk_in(clk_in), .nrst_in(nrst_in), .ref_a_in(ref_a),
    .ref_b_in(ref_b), .ref_sel_in(ref_sel), .fb_a_in(fb_a & ~fb_sel), .fb_b_in(fb_b),
    .fb_sel_in(fb_sel),
    .range_sel_in(range), .off_state_sel_in(off_st), .feedback_divide_sel_in(fdsel),
    .loop_phase_sel_in(lph), .feedback_bank_off_in(fb_off), .bank_divide_sel_in(dsel),
    .bank_phase_sel_in(psel), .bank_off_in(boff), .bank3_polarity_sel_in(pol),
    .bank_clk_out(bclk), .bank_clk_oe_n_out(boe), .loop_out_pair_out(lclk),
    .loop_out_oe_n_out(loe), .lock_out(lock), .osc_up_out(up), .osc_down_out(dn),
    .test_mode_out(tmode));
  board_clock_model board (.clk_in(clk_in), .run_in(run), .align_in(align),
    .fb_src_in(lclk[0]), .ref_a_out(ref_a), .ref_b_out(ref_b), .fb_a_out(fb_a),
    .fb_b_out(fb_b));
  task automatic cyc;
    @(posedge clk_in);
    #2;
  endtask
  task automatic settle;
    repeat (40) cyc;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic meas(input int i, output int hi, output int per);
    int n = 0;
    while (all_clk[i] !== 1'b0 && n < 2000) begin cyc; n++; end
    while (all_clk[i] !== 1'b1 && n < 2000) begin cyc; n++; end
    hi = 0;
    per = 0;
    while (all_clk[i] === 1'b1 && per < 2000) begin cyc; hi++; per++; end
    while (all_clk[i] === 1'b0 && per < 2000) begin cyc; per++; end
  endtask
  // Cycles from a rise of output a to the next rise of output b
  task automatic lag(input int a, input int b, output int d);
    int ra = -1;
    logic pa = 1'b1;
    logic pb = 1'b1;
    d = -1;
    for (int t = 0; t < 80 && d < 0; t++) begin
      if (all_clk[a] === 1'b1 && pa === 1'b0 && ra < 0) ra = t;
      if (ra >= 0 && all_clk[b] === 1'b1 && pb === 1'b0) d = t - ra;
      pa = all_clk[a];
      pb = all_clk[b];
      cyc;
    end
  endtask
  task automatic waitlock(input logic v);
    for (int n = 0; n < 3000 && lock !== v; n++) cyc;
  endtask
  task automatic t_div;
    int hi, per;
    for (int i = 0; i < 9; i++) begin
      dsel[0] = {tri_t'(i / 3), tri_t'(i % 3)};
      fdsel = dsel[0];
      settle;
      meas(0, hi, per);
      chk(per, 16 * dv[i]);
      chk(hi, 8 * dv[i]);
      meas(16, hi, per);
      chk(per, 16 * dv[i]);
    end
    dsel[0] = 4'h0;
    fdsel = 4'h0;
    range = TRI_LOW;
    settle;
    meas(0, hi, per);
    chk(per, 64);
    range = 2'h3;
    settle;
    meas(0, hi, per);
    chk(per, 32);
    range = TRI_HIGH;
    settle;
    $display("t_div done");
  endtask
  task automatic t_phase;
    int d;
    for (int i = 0; i < 9; i++) begin
      psel[0] = {tri_t'(i / 3), tri_t'(i % 3)};
      settle;
      lag(4, 0, d);
      chk(d, (o1[i] + 16) % 16);
    end
    // Bank 1 left at +3 so the copy code is visible on bank 3
    psel[0] = {TRI_HIGH, TRI_MID};
    for (int i = 0; i < 9; i++) begin
      psel[2] = {tri_t'(i / 3), tri_t'(i % 3)};
      settle;
      lag(4, 8, d);
      chk(d, (o3[i] + 16) % 16);
    end
    psel = 16'h5555;
    for (int i = 0; i < 3; i++) begin
      lph = tri_t'(i);
      settle;
      lag(4, 16, d);
      chk(d, (4 * i + 12) % 16);
    end
    lph = TRI_MID;
    $display("t_phase done");
  endtask
  task automatic t_pol;
    logic [3:0] mask[3] = '{4'ha, 4'hf, 4'h0};
    tri_t pv[3] = '{TRI_LOW, TRI_HIGH, TRI_MID};
    for (int i = 0; i < 3; i++) begin
      pol = pv[i];
      settle;
      repeat (20) begin
        cyc;
        chk(bclk[11:8], bclk[15:12] ^ mask[i]);
      end
    end
    $display("t_pol done");
  endtask
  task automatic t_dis;
    int hi, per;
    for (int n = 0; n < 40 && bclk[0] === 1'b1; n++) cyc;
    for (int n = 0; n < 40 && bclk[0] !== 1'b1; n++) cyc;
    cyc;
    boff[0] = 1'b1;
    hi = 1;
    while (bclk[0] === 1'b1 && hi < 40) begin cyc; hi++; end
    chk(hi, 8);
    settle;
    chk({boe[3:0], bclk[3:0]}, 8'h00);
    meas(4, hi, per);
    chk(per, 16);
    off_st = TRI_HIGH;
    repeat (810) cyc;
    chk(boe[7:0], 8'h0f);
    boff[0] = 1'b0;
    settle;
    meas(0, hi, per);
    chk({boe[3:0], per[7:0]}, 12'h010);
    fb_off = 1'b1;
    repeat (810) cyc;
    chk({loe, lclk}, 4'hc);
    fb_off = 1'b0;
    settle;
    meas(16, hi, per);
    chk({loe, per[7:0]}, 10'h010);
    off_st = TRI_MID;
    repeat (3) cyc;
    chk(tmode, 1'b1);
    off_st = TRI_LOW;
    repeat (3) cyc;
    chk(tmode, 1'b0);
    $display("t_dis done");
  endtask
  task automatic t_lock;
    run = 1'b1;
    align = 1'b1;
    waitlock(1'b1);
    chk(lock, 1'b1);
    ref_sel = 1'b1;
    fb_sel = 1'b1;
    cyc;
    cyc;
    chk(lock, 1'b0);
    waitlock(1'b1);
    chk(lock, 1'b1);
    lph = TRI_HIGH;
    for (int n = 0; n < 48 && up !== 1'b1; n++) cyc;
    chk(up, 1'b1);
    lph = TRI_MID;
    waitlock(1'b1);
    run = 1'b0;
    waitlock(1'b0);
    chk(lock, 1'b0);
    $display("t_lock done");
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Ceiling sits well above the expected run of some 10000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (2) @(posedge clk_in);
    #2 nrst_in = 1'b1;
    settle;
    t_div;
    t_phase;
    t_pol;
    t_dis;
    t_lock;
    tally_and_finish;
  end
endmodule
`default_nettype wire
